// ===== hfpd_pkg.sv
// Package: constants, datagram layouts and structs for the heater process-data block
package hfpd_pkg;

    localparam int          HFPD_CHANNELS      = 12;
    localparam int          HFPD_PCT_CHANNELS  = 10;
    localparam int          HFPD_WORD_OUT_LEN  = 37;
    localparam int          HFPD_SHORT_OUT_LEN = 13;
    localparam int          HFPD_WORD_IN_LEN   = 5;
    localparam int          HFPD_BYTE_OUT_LEN  = 11;
    localparam int          HFPD_BYTE_IN_LEN   = 6;
    localparam int          HFPD_USER_PRM_LEN  = 5;
    localparam int          HFPD_MAX_BYTES     = 74;
    localparam int          HFPD_IDX_W         = 7;

    // Output datagram layout
    localparam int          HFPD_CMD_ON_BIT    = 4;
    localparam int          HFPD_SETPT_WORD0   = 1;
    localparam int          HFPD_LAMP_SERVICE_VOLTAGE_WORD0    = 13;
    localparam int          HFPD_NOMP_WORD0    = 25;

    // Input byte 0 layout
    localparam int          HFPD_IN_SECTOR_BIT = 7;
    localparam int          HFPD_IN_HEAT_BIT   = 6;
    localparam int          HFPD_IN_CUT_BIT    = 5;
    localparam int          HFPD_IN_ON_BIT     = 4;
    localparam int          HFPD_IN_OVLD_BIT   = 3;
    localparam int          HFPD_IN_RANGE_BIT  = 2;

    localparam logic [7:0]  HFPD_PCT_MAX       = 8'h64;
    localparam logic [15:0] HFPD_LOW_SECTOR_V  = 16'h0168;
    localparam logic [7:0]  HFPD_ZERO_BYTE     = 8'h00;

    typedef enum logic [1:0]
    {
        HFPD_PROTO_FULL  = 2'h0,
        HFPD_PROTO_SHORT = 2'h1,
        HFPD_PROTO_BYTE  = 2'h2
    } hfpd_proto_t;

    typedef struct packed
    {
        logic sector_default_alarm;
        logic overheat_alarm;
        logic cutout_alarm;
        logic overload_alarm;
    } hfpd_alarm_t;

    typedef struct packed
    {
        logic                             regulation_on;
        logic [HFPD_CHANNELS-1:0][15:0]   power_watts;
        logic [HFPD_CHANNELS-1:0][15:0]   lamp_service_voltage;
        logic [HFPD_CHANNELS-1:0][15:0]   nominal_power;
        logic [HFPD_PCT_CHANNELS-1:0][7:0] power_percent;
        logic                             use_local_params;
    } hfpd_settings_t;

endpackage : hfpd_pkg

// ===== hfpd_addr_latch.sv
// Slave address capture from the rotary switches at power-up
`timescale 1ns/1ps
module hfpd_addr_latch
    import hfpd_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       rstn_in,
    input  wire logic [3:0] address_low_switch_in,
    input  wire logic [3:0] address_high_switch_in,
    output logic      [7:0] slave_bus_address_out,
    output logic            address_valid_out
);

    typedef struct packed
    {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [1:0] settle;
        logic [7:0] addr;
        logic       valid;
    } hfpd_addr_state_t;

    hfpd_addr_state_t st_r;
    hfpd_addr_state_t st_nxt;

    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.sync1 = {address_high_switch_in, address_low_switch_in};
        st_nxt.sync2 = st_r.sync1;
        if (!st_r.valid)
        begin
            // Wait until the synchroniser holds switch values, then freeze
            if (st_r.settle != 2'h3)
            begin
                st_nxt.settle = st_r.settle + 2'h1;
            end
            else
            begin
                st_nxt.addr  = st_r.sync2;
                st_nxt.valid = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign slave_bus_address_out = st_r.addr;
    assign address_valid_out     = st_r.valid;

endmodule : hfpd_addr_latch

// ===== hfpd_in_builder.sv
// Input datagram byte builder for all protocols
`timescale 1ns/1ps
module hfpd_in_builder
    import hfpd_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rstn_in,
    input  wire hfpd_proto_t proto_in,
    input  wire hfpd_alarm_t alarms_in,
    input  wire logic        regulation_on_in,
    input  wire logic [15:0] supply_voltage_in,
    input  wire logic [HFPD_CHANNELS-1:0] dead_lamp_in,
    input  wire logic [HFPD_CHANNELS-1:0] power_not_ok_in,
    input  wire logic [HFPD_IDX_W-1:0]    rd_idx_in,
    output logic      [7:0]  rd_data_out
);

    typedef struct packed
    {
        logic [7:0] data;
    } hfpd_inb_state_t;

    hfpd_inb_state_t st_r;
    hfpd_inb_state_t st_nxt;
    logic [7:0]      status_byte;
    logic [15:0]     dead_bytes;
    logic [15:0]     pnok_word;

    always_comb
    begin
        status_byte                      = HFPD_ZERO_BYTE;
        status_byte[HFPD_IN_SECTOR_BIT]  = alarms_in.sector_default_alarm;
        status_byte[HFPD_IN_HEAT_BIT]    = alarms_in.overheat_alarm;
        status_byte[HFPD_IN_CUT_BIT]     = alarms_in.cutout_alarm;
        status_byte[HFPD_IN_ON_BIT]      = regulation_on_in;
        status_byte[HFPD_IN_OVLD_BIT]    = alarms_in.overload_alarm;
        status_byte[HFPD_IN_RANGE_BIT]   = (supply_voltage_in < HFPD_LOW_SECTOR_V);
        // Lamp 1 in bit 8 up to lamp 8 in bit 15, lamps 9,10 in byte 5 bits 0,1
        dead_bytes = {dead_lamp_in[7:0], 6'h00, dead_lamp_in[9], dead_lamp_in[8]};
        pnok_word  = {4'h0, power_not_ok_in};
        st_nxt.data = HFPD_ZERO_BYTE;
        if (proto_in == HFPD_PROTO_BYTE)
        begin
            unique case (rd_idx_in)
                7'h00:   st_nxt.data = status_byte;
                7'h02:   st_nxt.data = supply_voltage_in[15:8];
                7'h03:   st_nxt.data = supply_voltage_in[7:0];
                7'h04:   st_nxt.data = dead_bytes[15:8];
                7'h05:   st_nxt.data = dead_bytes[7:0];
                default: st_nxt.data = HFPD_ZERO_BYTE;
            endcase
        end
        else
        begin
            unique case (rd_idx_in)
                7'h00:   st_nxt.data = status_byte;
                7'h02:   st_nxt.data = pnok_word[15:8];
                7'h03:   st_nxt.data = pnok_word[7:0];
                7'h04:   st_nxt.data = {4'h0, dead_lamp_in[11:8]};
                7'h05:   st_nxt.data = dead_lamp_in[7:0];
                7'h08:   st_nxt.data = supply_voltage_in[15:8];
                7'h09:   st_nxt.data = supply_voltage_in[7:0];
                default: st_nxt.data = HFPD_ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rd_data_out = st_r.data;

endmodule : hfpd_in_builder

// ===== hfpd_process_data.sv
// Top: process-data mapping of the heater regulator fieldbus slave
`timescale 1ns/1ps
module hfpd_process_data
    import hfpd_pkg::*;
(
    input  wire logic                     sys_clk_in,
    input  wire logic                     rstn_in,
    input  wire hfpd_proto_t              proto_in,
    input  wire logic                     frame_start_in,
    input  wire logic                     out_byte_valid_in,
    input  wire logic [7:0]               out_byte_in,
    input  wire logic                     frame_end_in,
    input  wire logic                     prm_byte_valid_in,
    input  wire logic [7:0]               prm_byte_in,
    input  wire logic [HFPD_IDX_W-1:0]    in_rd_idx_in,
    output logic      [7:0]               in_rd_data_out,
    output logic      [HFPD_IDX_W-1:0]    in_len_out,
    output logic      [HFPD_IDX_W-1:0]    out_len_out,
    output logic                          ext_diag_len_zero_out,
    input  wire logic [HFPD_CHANNELS-1:0][15:0] local_service_voltage_in,
    input  wire logic [HFPD_CHANNELS-1:0][15:0] local_nominal_power_in,
    input  wire hfpd_alarm_t              alarms_in,
    input  wire logic [15:0]              supply_voltage_in,
    input  wire logic [HFPD_CHANNELS-1:0] dead_lamp_in,
    input  wire logic [HFPD_CHANNELS-1:0] power_not_ok_in,
    input  wire logic [3:0]               address_low_switch_in,
    input  wire logic [3:0]               address_high_switch_in,
    output logic      [7:0]               slave_bus_address_out,
    output logic                          address_valid_out,
    output hfpd_settings_t                settings_out,
    output logic                          settings_update_out,
    output logic                          frame_error_out
);

    typedef enum logic [2:0]
    {
        HFPD_ST_IDLE = 3'b001,
        HFPD_ST_RECV = 3'b010,
        HFPD_ST_DONE = 3'b100
    } hfpd_fsm_t;

    typedef struct packed
    {
        hfpd_fsm_t                          fsm;
        logic [HFPD_IDX_W-1:0]              count;
        logic [HFPD_MAX_BYTES-1:0][7:0]     shadow;
        hfpd_settings_t                     applied;
        logic                               update;
        logic                               error;
        logic [2:0]                         prm_count;
    } hfpd_state_t;

    hfpd_state_t st_r;
    hfpd_state_t st_nxt;

    function automatic logic [HFPD_IDX_W-1:0] out_len(input hfpd_proto_t p);
        unique case (p)
            HFPD_PROTO_FULL:  out_len = 7'(2 * HFPD_WORD_OUT_LEN);
            HFPD_PROTO_SHORT: out_len = 7'(2 * HFPD_SHORT_OUT_LEN);
            default:          out_len = 7'(HFPD_BYTE_OUT_LEN);
        endcase
    endfunction : out_len

    function automatic logic [HFPD_IDX_W-1:0] in_len(input hfpd_proto_t p);
        if (p == HFPD_PROTO_BYTE)
        begin
            in_len = 7'(HFPD_BYTE_IN_LEN);
        end
        else
        begin
            in_len = 7'(2 * HFPD_WORD_IN_LEN);
        end
    endfunction : in_len

    // Word n (zero based) from the shadow, high byte first
    function automatic logic [15:0] word_at(input logic [HFPD_MAX_BYTES-1:0][7:0] sh, input int n);
        word_at = {sh[2*n], sh[2*n+1]};
    endfunction : word_at

    function automatic logic [7:0] clamp_pct(input logic [7:0] v);
        clamp_pct = (v > HFPD_PCT_MAX) ? HFPD_PCT_MAX : v;
    endfunction : clamp_pct

    logic [HFPD_IDX_W-1:0] exp_len;
    assign exp_len = out_len(proto_in);

    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.update = 1'b0;
        // User parameter bytes are counted but never acted on
        if (prm_byte_valid_in && st_r.prm_count != 3'(HFPD_USER_PRM_LEN))
        begin
            st_nxt.prm_count = st_r.prm_count + 3'h1;
        end
        unique case (st_r.fsm)
            HFPD_ST_IDLE:
            begin
                if (frame_start_in)
                begin
                    st_nxt.fsm   = HFPD_ST_RECV;
                    st_nxt.count = '0;
                end
            end
            HFPD_ST_RECV:
            begin
                if (out_byte_valid_in)
                begin
                    if (st_r.count < exp_len)
                    begin
                        st_nxt.shadow[st_r.count] = out_byte_in;
                        st_nxt.count              = st_r.count + 7'h1;
                    end
                    else
                    begin
                        st_nxt.error = 1'b1;
                    end
                end
                if (frame_end_in)
                begin
                    // Short datagram, or overlong one whose frame end comes with its last byte, is dropped whole
                    if (st_nxt.count == exp_len && !(out_byte_valid_in && st_r.count >= exp_len))
                    begin
                        st_nxt.fsm   = HFPD_ST_DONE;
                        st_nxt.error = 1'b0;
                    end
                    else
                    begin
                        st_nxt.fsm   = HFPD_ST_IDLE;
                        st_nxt.error = 1'b1;
                    end
                end
            end
            HFPD_ST_DONE:
            begin
                st_nxt.fsm    = HFPD_ST_IDLE;
                st_nxt.update = 1'b1;
                st_nxt.applied.use_local_params = (proto_in == HFPD_PROTO_SHORT);
                if (proto_in == HFPD_PROTO_BYTE)
                begin
                    st_nxt.applied.regulation_on = st_r.shadow[0][HFPD_CMD_ON_BIT];
                    for (int c = 0; c < HFPD_PCT_CHANNELS; c++)
                    begin
                        st_nxt.applied.power_percent[c] = clamp_pct(st_r.shadow[c+1]);
                    end
                end
                else
                begin
                    // Only bit weight 10000 of byte 0; byte 1 is ignored
                    st_nxt.applied.regulation_on = st_r.shadow[0][HFPD_CMD_ON_BIT];
                    for (int c = 0; c < HFPD_CHANNELS; c++)
                    begin
                        st_nxt.applied.power_watts[c] = word_at(st_r.shadow, HFPD_SETPT_WORD0 + c);
                        if (proto_in == HFPD_PROTO_FULL)
                        begin
                            st_nxt.applied.lamp_service_voltage[c] =
                                word_at(st_r.shadow, HFPD_LAMP_SERVICE_VOLTAGE_WORD0 + c);
                            st_nxt.applied.nominal_power[c] =
                                word_at(st_r.shadow, HFPD_NOMP_WORD0 + c);
                        end
                        else
                        begin
                            st_nxt.applied.lamp_service_voltage[c] = local_service_voltage_in[c];
                            st_nxt.applied.nominal_power[c]        = local_nominal_power_in[c];
                        end
                    end
                end
            end
            default:
            begin
                st_nxt.fsm = HFPD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            st_r     <= '0;
            st_r.fsm <= HFPD_ST_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign settings_out          = st_r.applied;
    assign settings_update_out   = st_r.update;
    assign frame_error_out       = st_r.error;
    assign in_len_out            = in_len(proto_in);
    assign out_len_out           = exp_len;
    assign ext_diag_len_zero_out = 1'b1;

    hfpd_in_builder u_in_builder
    (
        .sys_clk_in        (sys_clk_in),
        .rstn_in           (rstn_in),
        .proto_in          (proto_in),
        .alarms_in         (alarms_in),
        .regulation_on_in  (st_r.applied.regulation_on),
        .supply_voltage_in (supply_voltage_in),
        .dead_lamp_in      (dead_lamp_in),
        .power_not_ok_in   (power_not_ok_in),
        .rd_idx_in         (in_rd_idx_in),
        .rd_data_out       (in_rd_data_out)
    );

    hfpd_addr_latch u_addr_latch
    (
        .sys_clk_in             (sys_clk_in),
        .rstn_in                (rstn_in),
        .address_low_switch_in  (address_low_switch_in),
        .address_high_switch_in (address_high_switch_in),
        .slave_bus_address_out  (slave_bus_address_out),
        .address_valid_out      (address_valid_out)
    );

endmodule : hfpd_process_data

// ===== hfpd_asserts.sv
// Assertion checker for the heater process-data top
`timescale 1ns/1ps
module hfpd_asserts
    import hfpd_pkg::*;
(
    input  wire logic                  sys_clk_in,
    input  wire logic                  rstn_in,
    input  wire hfpd_proto_t           proto_in,
    input  wire logic [HFPD_IDX_W-1:0] in_rd_idx_in,
    input  wire logic [7:0]            in_rd_data_out,
    input  wire logic [HFPD_IDX_W-1:0] in_len_out,
    input  wire logic [HFPD_IDX_W-1:0] out_len_out,
    input  wire logic                  ext_diag_len_zero_out,
    input  wire hfpd_alarm_t           alarms_in,
    input  wire logic [15:0]           supply_voltage_in,
    input  wire logic [7:0]            slave_bus_address_out,
    input  wire logic                  address_valid_out,
    input  wire hfpd_settings_t        settings_out,
    input  wire logic                  settings_update_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);

    logic pct_ok;

    always_comb
    begin
        pct_ok = 1'b1;
        for (int i = 0; i < HFPD_PCT_CHANNELS; i++)
            if (settings_out.power_percent[i] > HFPD_PCT_MAX)
                pct_ok = 1'b0;
    end

    // Index sampled now, byte answered on the next edge
    sequence s_ask(int k);
        in_rd_idx_in == k;
    endsequence

    sequence s_ask_byte(int k);
        proto_in == HFPD_PROTO_BYTE && in_rd_idx_in == k;
    endsequence

    AST_ALARM_BITS: assert property (s_ask(0) |=> {in_rd_data_out[7:5], in_rd_data_out[3]} == $past(alarms_in))
        else $error("alarm bits wrong");
    AST_LOW_SUPPLY: assert property (s_ask(0) |=> in_rd_data_out[2] == ($past(supply_voltage_in) < HFPD_LOW_SECTOR_V))
        else $error("low supply bit wrong");
    AST_RESV_BYTE: assert property (s_ask(1) |=> in_rd_data_out == 8'h00)
        else $error("reserved input byte not zero");
    AST_VOLT_HIGH: assert property (s_ask_byte(2) |=> {in_rd_data_out, 8'h00} == ($past(supply_voltage_in) & 16'hff00))
        else $error("voltage high byte wrong");
    AST_VOLT_LOW: assert property (s_ask_byte(3) |=> {8'h00, in_rd_data_out} == ($past(supply_voltage_in) & 16'h00ff))
        else $error("voltage low byte wrong");
    AST_LEN_BYTE: assert property (proto_in == HFPD_PROTO_BYTE |-> out_len_out == 7'h0b && in_len_out == 7'h06)
        else $error("byte mode lengths wrong");
    AST_LEN_FULL: assert property (proto_in == HFPD_PROTO_FULL |-> out_len_out == 7'h4a && in_len_out == 7'h0a)
        else $error("full mode lengths wrong");
    AST_NO_DIAG: assert property (ext_diag_len_zero_out)
        else $error("extended diagnostics offered");
    AST_PCT_CLAMP: assert property (pct_ok)
        else $error("percent above limit");
    AST_APPLY_PULSE: assert property (settings_update_out |=> !settings_update_out)
        else $error("update pulse too long");
    AST_APPLY_TOGETHER: assert property ($changed(settings_out) |-> settings_update_out)
        else $error("settings changed without update");
    AST_SHORT_LOCAL: assert property (settings_update_out && proto_in == HFPD_PROTO_SHORT |-> settings_out.use_local_params)
        else $error("short mode not using local values");
    AST_ADDR_FROZEN: assert property ($past(address_valid_out) |-> address_valid_out && $stable(slave_bus_address_out))
        else $error("address changed after capture");
endmodule : hfpd_asserts

bind hfpd_process_data hfpd_asserts chk_u
(
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .proto_in(proto_in),
    .in_rd_idx_in(in_rd_idx_in),
    .in_rd_data_out(in_rd_data_out),
    .in_len_out(in_len_out),
    .out_len_out(out_len_out),
    .ext_diag_len_zero_out(ext_diag_len_zero_out),
    .alarms_in(alarms_in),
    .supply_voltage_in(supply_voltage_in),
    .slave_bus_address_out(slave_bus_address_out),
    .address_valid_out(address_valid_out),
    .settings_out(settings_out),
    .settings_update_out(settings_update_out)
);

// ===== hfpd_master_model.sv
// Bus master model: sends output datagrams to the slave
`timescale 1ns/1ps
module hfpd_master_model
(
    input  wire logic sys_clk_in,
    output logic      frame_start_out,
    output logic      byte_valid_out,
    output logic [7:0] byte_out,
    output logic      frame_end_out
);
    initial
    begin
        frame_start_out = 1'b0;
        byte_valid_out  = 1'b0;
        byte_out        = 8'h00;
        frame_end_out   = 1'b0;
    end

    // Setpoints and start bit travel in one coherent datagram; gap makes a slow master
    task automatic send(input logic [7:0] b [75], input int n, input int gap);
        @(posedge sys_clk_in);
        frame_start_out <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(posedge sys_clk_in);
            frame_start_out <= 1'b0;
            byte_valid_out  <= 1'b1;
            byte_out        <= b[i];
            frame_end_out   <= (i == n - 1);
            repeat (gap)
            begin
                @(posedge sys_clk_in);
                byte_valid_out <= 1'b0;
                frame_end_out  <= 1'b0;
                byte_out       <= ~b[i];
            end
        end
        @(posedge sys_clk_in);
        byte_valid_out <= 1'b0;
        frame_end_out  <= 1'b0;
        byte_out       <= ~b[n-1];
        repeat (2) @(posedge sys_clk_in);
    endtask : send
endmodule : hfpd_master_model

// ===== heater_fieldbus_process_data_tb_top.sv
// Self-checking bench for the heater process-data block
`timescale 1ns/1ps
module heater_fieldbus_process_data_tb_top
    import hfpd_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    hfpd_proto_t proto = HFPD_PROTO_FULL;
    logic fs, bv, fe, upd, ferr;
    logic pv = 1'b0;
    logic [7:0] ob8, rd, addr;
    logic [7:0] pb = 8'h00;
    logic [HFPD_IDX_W-1:0] idx = 7'h00;
    logic [HFPD_CHANNELS-1:0][15:0] lsv, lnp;
    hfpd_alarm_t alm = 4'h0;
    logic [15:0] sv = 16'h0000;
    logic [HFPD_CHANNELS-1:0] dead = 12'h000;
    logic [HFPD_CHANNELS-1:0] pnok = 12'h000;
    logic [3:0] swl = 4'h5;
    logic [3:0] swh = 4'h1;
    hfpd_settings_t st;
    logic [7:0] ob [75];
    logic [7:0] gob [75];
    logic on_exp = 1'b0;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    int ucnt = 0;
    integer seed = 32'h3697;

    hfpd_process_data dut_u (.sys_clk_in(clk), .rstn_in(rstn), .proto_in(proto), .frame_start_in(fs),
        .out_byte_valid_in(bv), .out_byte_in(ob8), .frame_end_in(fe), .prm_byte_valid_in(pv), .prm_byte_in(pb),
        .in_rd_idx_in(idx), .in_rd_data_out(rd), .in_len_out(), .out_len_out(), .ext_diag_len_zero_out(),
        .local_service_voltage_in(lsv), .local_nominal_power_in(lnp), .alarms_in(alm), .supply_voltage_in(sv),
        .dead_lamp_in(dead), .power_not_ok_in(pnok), .address_low_switch_in(swl), .address_high_switch_in(swh),
        .slave_bus_address_out(addr), .address_valid_out(), .settings_out(st), .settings_update_out(upd),
        .frame_error_out(ferr));

    hfpd_master_model mm_u (.sys_clk_in(clk), .frame_start_out(fs), .byte_valid_out(bv), .byte_out(ob8),
        .frame_end_out(fe));

    always #5 clk = ~clk;

    task automatic end_of_test;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    always @(posedge clk)
    begin
        cyc++;
        if (upd === 1'b1)
            ucnt++;
        if (cyc == 30000)
        begin
            errors++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [7:0] exp_in(input hfpd_proto_t p, input int i);
        logic [7:0]  s;
        logic [15:0] pn;
        logic [15:0] dl;
        s  = {alm.sector_default_alarm, alm.overheat_alarm, alm.cutout_alarm, on_exp, alm.overload_alarm,
              sv < HFPD_LOW_SECTOR_V, 2'b00};
        pn = {4'h0, pnok};
        dl = {4'h0, dead};
        if (i == 0)
            return s;
        if (p == HFPD_PROTO_BYTE)
            case (i)
                2: return sv[15:8];
                3: return sv[7:0];
                4: return dead[7:0];
                5: return {6'h00, dead[9], dead[8]};
                default: return 8'h00;
            endcase
        case (i)
            2: return pn[15:8];
            3: return pn[7:0];
            4: return dl[15:8];
            5: return dl[7:0];
            8: return sv[15:8];
            9: return sv[7:0];
            default: return 8'h00;
        endcase
    endfunction : exp_in

    task automatic read_all(input hfpd_proto_t p);
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk);
            idx <= 7'(i);
            repeat (2) @(posedge clk);
            check("input byte", rd, exp_in(p, i));
        end
    endtask : read_all

    // Sends one datagram d bytes off its proper length and checks what was applied
    task automatic frame(input hfpd_proto_t p, input int d, input int gap);
        int n;
        int u;
        n = (p == HFPD_PROTO_FULL) ? 74 : (p == HFPD_PROTO_SHORT) ? 26 : 11;
        for (int i = 0; i < 75; i++)
            ob[i] = 8'($random(seed));
        ob[1] = (p == HFPD_PROTO_BYTE) ? 8'h64 : ob[1];
        ob[2] = (p == HFPD_PROTO_BYTE) ? 8'h65 : ob[2];
        u = ucnt;
        mm_u.send(ob, n + d, gap);
        repeat (4) @(posedge clk);
        check("update count", 16'(ucnt - u), 16'(d == 0));
        check("frame error", 16'(ferr), 16'(d != 0));
        if (d == 0)
        begin
            gob = ob;
            on_exp = ob[0][HFPD_CMD_ON_BIT];
        end
        check("regulation on", 16'(st.regulation_on), 16'(on_exp));
        for (int c = 0; c < HFPD_CHANNELS; c++)
            if (p != HFPD_PROTO_BYTE)
            begin
                check("watts", st.power_watts[c], {gob[2*c+2], gob[2*c+3]});
                check("service v", st.lamp_service_voltage[c],
                      p == HFPD_PROTO_FULL ? {gob[2*c+26], gob[2*c+27]} : lsv[c]);
                check("nominal", st.nominal_power[c],
                      p == HFPD_PROTO_FULL ? {gob[2*c+50], gob[2*c+51]} : lnp[c]);
            end
            else if (c < HFPD_PCT_CHANNELS)
                check("percent", 16'(st.power_percent[c]),
                      16'((gob[c+1] > HFPD_PCT_MAX) ? HFPD_PCT_MAX : gob[c+1]));
    endtask : frame

    initial
    begin
        for (int c = 0; c < HFPD_CHANNELS; c++)
        begin
            lsv[c] = 16'($random(seed));
            lnp[c] = 16'($random(seed));
        end
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
        check("address", 16'(addr), 16'h0015);
        swl <= 4'h3;
        swh <= 4'ha;
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            pv <= 1'b1;
            pb <= 8'($random(seed));
        end
        @(posedge clk);
        pv <= 1'b0;
        check("address kept", 16'(addr), 16'h0015);
        for (int r = 0; r < 3; r++)
            for (int q = 0; q < 3; q++)
            begin
                @(posedge clk);
                proto <= hfpd_proto_t'(q);
                frame(hfpd_proto_t'(q), 0, r);
                frame(hfpd_proto_t'(q), -1, 0);
                frame(hfpd_proto_t'(q), 1, 0);
                @(posedge clk);
                alm  <= 4'($random(seed));
                sv   <= (r == 0) ? 16'h0167 : (r == 1) ? 16'h0168 : 16'($random(seed));
                dead <= 12'($random(seed));
                pnok <= 12'($random(seed));
                read_all(hfpd_proto_t'(q));
            end
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
        check("address reloaded", 16'(addr), 16'h00a3);
        on_exp = 1'b0;
        frame(HFPD_PROTO_BYTE, 0, 1);
        end_of_test();
    end
endmodule : heater_fieldbus_process_data_tb_top
